// *** card_pwr_pkg.sv ***
package card_pwr_pkg;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   // debounce counted in core_clk cycles, default 2 ms at 10 MHz
   localparam int DEBOUNCE_CYCLES_DEF = 20000;
   localparam int CNT_W = 16;
   // host holds the switch a little past the debounce period
   localparam int HOLD_MARGIN = 16;

   // ----------------------------------------
   // pin levels
   // ----------------------------------------
   localparam logic SEL_ON_N = 1'b0;
   localparam logic SEL_OFF_N = 1'b1;
   localparam logic SW_PRESSED_N = 1'b0;
   localparam logic SW_RELEASED_N = 1'b1;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      VCC_OFF = 2'h0,
      VCC_1V8 = 2'h1,
      VCC_3V0 = 2'h2,
      VCC_5V0 = 2'h3
   } vcc_sel_t;

   typedef enum logic [3:0] {
      PWR_OFF = 4'h1,
      PWR_ON = 4'h2,
      PWR_REQ = 4'h4,
      PWR_DEACT = 4'h8
   } pwr_state_t;

   // ----------------------------------------
   // select pin coding, a = high select, b = low select
   // ----------------------------------------
   function automatic vcc_sel_t decode_sel(input logic a_n, input logic b_n);
      vcc_sel_t v;
      v = VCC_OFF;
      if (a_n == SEL_ON_N && b_n == SEL_ON_N)
         v = VCC_1V8;
      else if (a_n == SEL_ON_N)
         v = VCC_5V0;
      else if (b_n == SEL_ON_N)
         v = VCC_3V0;
      return v;
   endfunction : decode_sel

   function automatic logic [1:0] encode_sel(input vcc_sel_t v);
      logic [1:0] p;
      p = {SEL_OFF_N, SEL_OFF_N};
      unique case (v)
         VCC_1V8: p = {SEL_ON_N, SEL_ON_N};
         VCC_5V0: p = {SEL_ON_N, SEL_OFF_N};
         VCC_3V0: p = {SEL_OFF_N, SEL_ON_N};
         VCC_OFF: p = {SEL_OFF_N, SEL_OFF_N};
      endcase
      return p;
   endfunction : encode_sel

endpackage : card_pwr_pkg

// *** card_pwr_if.sv ***
`timescale 1ns/1ns
interface card_pwr_if;
   // host driven
   logic supply_select_a_n;
   logic supply_select_b_n;
   logic card_reset_cmd;
   logic card_clock_src;
   logic card_mode_select;
   logic chip_select;
   logic power_switch_n;
   logic ack_out;
   logic ack_oe;
   // device driven
   logic shutdown_req;
   logic ready_drive_low;
   logic ready_pullup_en;
   logic fault_drive_low;
   logic fault_pullup_en;
   // resolved wires
   logic shutdown_ack;
   logic card_ready;
   logic fault_n;

   // undriven ack follows the request through the internal link
   assign shutdown_ack = ack_oe ? ack_out : shutdown_req;
   // open drain with switchable pull-up, floating reads low
   assign card_ready = ready_drive_low ? 1'b0 : ready_pullup_en;
   assign fault_n = fault_drive_low ? 1'b0 : fault_pullup_en;

   modport device (
      input supply_select_a_n, supply_select_b_n, card_reset_cmd, card_clock_src,
      input card_mode_select, chip_select, power_switch_n, shutdown_ack,
      output shutdown_req, ready_drive_low, ready_pullup_en,
      output fault_drive_low, fault_pullup_en
   );

   modport host (
      output supply_select_a_n, supply_select_b_n, card_reset_cmd, card_clock_src,
      output card_mode_select, chip_select, power_switch_n, ack_out, ack_oe,
      input shutdown_req, card_ready, fault_n
   );
endinterface : card_pwr_if

// *** card_supply_power_control.sv ***
// Summary of operation
// R1 - select pins pick 1.8, 5.0, 3.0 or off
// R2 - ready only after supply reaches selected level
// R3 - ready pull-up off when powered down or deselected
// R4 - turn on after switch low past debounce
// R5 - while on, debounced press raises shutdown request
// R6 - go off after debounce and handshake
// R7 - acknowledge high powers down analog, disconnects supply
// R8 - floating acknowledge follows request, off after deactivation
// R9 - host switch drive held low past debounce
// R10 - host reset command passes to card reset
// R11 - host clock source is sole card clock
// R12 - mode low links usb lines to aux
// R13 - chip select low latches supply select and reset inputs, blocks low drive
// R14 - no activation without card present
// R15 - card reset, clock low unless active, powered
// R16 - faults and presence changes pull fault low
// R17 - debounce length is a cycle parameter
// R18 - both selects high drops ready
`timescale 1ns/1ns
module card_supply_power_control
   import card_pwr_pkg::*;
#(
   parameter int DEBOUNCE_CYCLES = card_pwr_pkg::DEBOUNCE_CYCLES_DEF
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // host side pins
   card_pwr_if.device hp,
   // card and analog side
   input wire logic card_present,
   input wire logic supply_above_level,
   input wire logic supply_fault,
   output card_pwr_pkg::vcc_sel_t vcc_sel,
   output logic card_rst,
   output logic card_clk,
   output logic card_sig_en,
   output logic usb_link_en,
   output logic analog_en,
   output logic main_supply_connect
);
   import card_pwr_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   localparam logic [CNT_W-1:0] DEB_LAST = CNT_W'(DEBOUNCE_CYCLES - 1);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   pwr_state_t state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic armed_q, armed_d;
   logic sw_m_q, sw_m_d, sw_s_q, sw_s_d;
   logic card_present_m_q, card_present_m_d, card_present_s_q, card_present_s_d;
   logic lvl_m_q, lvl_m_d, lvl_s_q, lvl_s_d;
   logic flt_m_q, flt_m_d, flt_s_q, flt_s_d;
   logic card_present_prev_q, card_present_prev_d;
   logic flt_prev_q, flt_prev_d;
   logic sel_a_q, sel_a_d, sel_b_q, sel_b_d;
   logic rst_cmd_q, rst_cmd_d;
   vcc_sel_t vcc_q, vcc_d;
   logic ready_q, ready_d;
   logic fault_q, fault_d;
   logic req_q, req_d;
   logic card_rst_q, card_rst_d;
   logic card_clk_q, card_clk_d;
   logic mode_q, mode_d;

   logic press;
   logic powered;
   logic active;
   logic fault_evt;
   vcc_sel_t sel_eff;
   logic rst_eff;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      // switch, presence, level and fault pins pass two flops first
      sw_m_d = hp.power_switch_n;
      sw_s_d = sw_m_q;
      card_present_m_d = card_present;
      card_present_s_d = card_present_m_q;
      lvl_m_d = supply_above_level;
      lvl_s_d = lvl_m_q;
      flt_m_d = supply_fault;
      flt_s_d = flt_m_q;
      card_present_prev_d = card_present_s_q;
      flt_prev_d = flt_s_q;

      // deselected: hold the last seen levels
      sel_a_d = hp.chip_select ? hp.supply_select_a_n : sel_a_q; // R13
      sel_b_d = hp.chip_select ? hp.supply_select_b_n : sel_b_q; // R13
      rst_cmd_d = hp.chip_select ? hp.card_reset_cmd : rst_cmd_q; // R13
      sel_eff = decode_sel(sel_a_d, sel_b_d); // R1
      rst_eff = rst_cmd_d;

      // debounce: re-arms only after release so one hold is one event
      press = 1'b0;
      cnt_d = cnt_q;
      armed_d = armed_q;
      if (sw_s_q == SW_RELEASED_N)
      begin
         cnt_d = '0;
         armed_d = 1'b1;
      end
      else if (armed_q && cnt_q == DEB_LAST) // R17
      begin
         press = 1'b1; // R4
         cnt_d = '0;
         armed_d = 1'b0;
      end
      else if (armed_q)
      begin
         cnt_d = cnt_q + CNT_ONE;
      end

      state_d = state_q;
      unique case (state_q)
         PWR_OFF:
         begin
            if (press)
               state_d = PWR_ON; // R4
         end
         PWR_ON:
         begin
            if (press)
               state_d = PWR_REQ; // R5
         end
         PWR_REQ:
         begin
            if (hp.shutdown_ack)
               state_d = PWR_DEACT; // R6 R7 R8
         end
         PWR_DEACT:
         begin
            // card supply must be down before the main supply goes
            if (vcc_q == VCC_OFF && !lvl_s_q)
               state_d = PWR_OFF; // R8
         end
      endcase

      powered = (state_q == PWR_ON) || (state_q == PWR_REQ);
      active = (vcc_q != VCC_OFF);
      req_d = (state_d == PWR_REQ) || (state_d == PWR_DEACT); // R5

      // a pending fault blocks reactivation until host turns supply off
      vcc_d = VCC_OFF;
      if (powered && card_present_s_q && !fault_q) // R14
         vcc_d = sel_eff; // R1

      ready_d = active && lvl_s_q && (vcc_q == sel_eff)
                && (sel_eff != VCC_OFF); // R2 R18

      fault_evt = (card_present_s_q != card_present_prev_q)
                  || (flt_s_q && !flt_prev_q)
                  || (ready_q && active && !lvl_s_q);
      // set wins over clear
      fault_d = fault_evt || (fault_q && !(sel_eff == VCC_OFF && !active)); // R16

      mode_d = hp.card_mode_select;
      card_rst_d = (active && lvl_s_q && mode_q) ? rst_eff : 1'b0; // R10 R15
      card_clk_d = (active && lvl_s_q && mode_q) ? hp.card_clock_src : 1'b0; // R11 R15
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state_q <= PWR_OFF;
         cnt_q <= '0;
         armed_q <= 1'b0;
         sw_m_q <= SW_RELEASED_N;
         sw_s_q <= SW_RELEASED_N;
         card_present_m_q <= 1'b0;
         card_present_s_q <= 1'b0;
         lvl_m_q <= 1'b0;
         lvl_s_q <= 1'b0;
         flt_m_q <= 1'b0;
         flt_s_q <= 1'b0;
         card_present_prev_q <= 1'b0;
         flt_prev_q <= 1'b0;
         sel_a_q <= SEL_OFF_N;
         sel_b_q <= SEL_OFF_N;
         rst_cmd_q <= 1'b0;
         vcc_q <= VCC_OFF;
         ready_q <= 1'b0;
         fault_q <= 1'b0;
         req_q <= 1'b0;
         card_rst_q <= 1'b0;
         card_clk_q <= 1'b0;
         mode_q <= 1'b1;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         armed_q <= armed_d;
         sw_m_q <= sw_m_d;
         sw_s_q <= sw_s_d;
         card_present_m_q <= card_present_m_d;
         card_present_s_q <= card_present_s_d;
         lvl_m_q <= lvl_m_d;
         lvl_s_q <= lvl_s_d;
         flt_m_q <= flt_m_d;
         flt_s_q <= flt_s_d;
         card_present_prev_q <= card_present_prev_d;
         flt_prev_q <= flt_prev_d;
         sel_a_q <= sel_a_d;
         sel_b_q <= sel_b_d;
         rst_cmd_q <= rst_cmd_d;
         vcc_q <= vcc_d;
         ready_q <= ready_d;
         fault_q <= fault_d;
         req_q <= req_d;
         card_rst_q <= card_rst_d;
         card_clk_q <= card_clk_d;
         mode_q <= mode_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // card clock is resampled, so it is limited to half core_clk
   assign hp.shutdown_req = req_q; // R5
   assign hp.ready_pullup_en = powered && hp.chip_select; // R3
   assign hp.ready_drive_low = !ready_q && hp.chip_select; // R13
   assign hp.fault_pullup_en = powered && hp.chip_select; // R3
   assign hp.fault_drive_low = fault_q && hp.chip_select; // R13 R16
   assign vcc_sel = vcc_q;
   assign card_rst = card_rst_q;
   assign card_clk = card_clk_q;
   assign card_sig_en = mode_q;
   assign usb_link_en = !mode_q; // R12
   assign analog_en = powered; // R7
   assign main_supply_connect = (state_q != PWR_OFF); // R7

endmodule : card_supply_power_control

// *** card_pwr_host.sv ***
`timescale 1ns/1ns
module card_pwr_host
   import card_pwr_pkg::*;
#(
   parameter int DEBOUNCE_CYCLES = card_pwr_pkg::DEBOUNCE_CYCLES_DEF
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // pins toward the device
   card_pwr_if.host hp,
   // user commands
   input card_pwr_pkg::vcc_sel_t user_vcc_sel,
   input wire logic user_card_reset,
   input wire logic user_card_clock,
   input wire logic user_card_mode,
   input wire logic user_chip_select,
   input wire logic user_power_toggle,
   input wire logic user_ack_drive,
   input wire logic user_ack_grant,
   // user status
   output logic toggle_busy,
   output logic card_ready,
   output logic fault_seen,
   output logic shutdown_pending
);
   import card_pwr_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(DEBOUNCE_CYCLES + HOLD_MARGIN);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   logic [1:0] sel_q, sel_d;
   logic rst_q, rst_d;
   logic clk_q, clk_d;
   logic mode_q, mode_d;
   logic cs_q, cs_d;
   logic sw_n_q, sw_n_d;
   logic [CNT_W-1:0] hold_q, hold_d;
   logic ack_oe_q, ack_oe_d;
   logic ack_q, ack_d;
   logic ready_q, ready_d;
   logic fault_q, fault_d;
   logic pend_q, pend_d;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      sel_d = encode_sel(user_vcc_sel); // R1
      rst_d = user_card_reset; // R10
      clk_d = user_card_clock; // R11
      mode_d = user_card_mode;
      cs_d = user_chip_select;
      ack_oe_d = user_ack_drive;
      ack_d = user_ack_grant && hp.shutdown_req;
      // status is qualified by select, pins float while deselected
      ready_d = hp.card_ready && cs_q;
      fault_d = !hp.fault_n && cs_q;
      pend_d = hp.shutdown_req;

      sw_n_d = sw_n_q;
      hold_d = hold_q;
      if (sw_n_q == SW_PRESSED_N)
      begin
         if (hold_q == HOLD_LAST)
         begin
            sw_n_d = SW_RELEASED_N;
            hold_d = '0;
         end
         else
         begin
            hold_d = hold_q + CNT_ONE; // R9
         end
      end
      else if (user_power_toggle)
      begin
         sw_n_d = SW_PRESSED_N; // R9
         hold_d = '0;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         sel_q <= {SEL_OFF_N, SEL_OFF_N};
         rst_q <= 1'b0;
         clk_q <= 1'b0;
         mode_q <= 1'b1;
         cs_q <= 1'b0;
         sw_n_q <= SW_RELEASED_N;
         hold_q <= '0;
         ack_oe_q <= 1'b0;
         ack_q <= 1'b0;
         ready_q <= 1'b0;
         fault_q <= 1'b0;
         pend_q <= 1'b0;
      end
      else
      begin
         sel_q <= sel_d;
         rst_q <= rst_d;
         clk_q <= clk_d;
         mode_q <= mode_d;
         cs_q <= cs_d;
         sw_n_q <= sw_n_d;
         hold_q <= hold_d;
         ack_oe_q <= ack_oe_d;
         ack_q <= ack_d;
         ready_q <= ready_d;
         fault_q <= fault_d;
         pend_q <= pend_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign hp.supply_select_a_n = sel_q[1];
   assign hp.supply_select_b_n = sel_q[0];
   assign hp.card_reset_cmd = rst_q;
   assign hp.card_clock_src = clk_q;
   assign hp.card_mode_select = mode_q;
   assign hp.chip_select = cs_q;
   assign hp.power_switch_n = sw_n_q;
   assign hp.ack_oe = ack_oe_q; // R8
   assign hp.ack_out = ack_q;
   assign toggle_busy = (sw_n_q == SW_PRESSED_N);
   assign card_ready = ready_q;
   assign fault_seen = fault_q;
   assign shutdown_pending = pend_q;

endmodule : card_pwr_host

// *** card_supply_power_control_assertions.sv ***
`timescale 1ns/1ns
module card_supply_power_control_checker
   import card_pwr_pkg::*;
#(
   parameter int DEBOUNCE_CYCLES = card_pwr_pkg::DEBOUNCE_CYCLES_DEF
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // host driven
   input wire logic supply_select_a_n,
   input wire logic supply_select_b_n,
   input wire logic chip_select,
   input wire logic power_switch_n,
   input wire logic ack_oe,
   // device driven and resolved
   input wire logic shutdown_req,
   input wire logic shutdown_ack,
   input wire logic ready_drive_low,
   input wire logic ready_pullup_en,
   input wire logic fault_drive_low,
   input wire logic fault_pullup_en,
   input wire logic card_ready
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   // ----------------------------------------
   // helper state
   // ----------------------------------------
   // run_q keeps the length of the last press after release
   logic [CNT_W-1:0] run_q;
   logic [CNT_W-1:0] run_d;
   logic sw_prev_q;
   logic ack_seen_q;
   logic ack_seen_d;
   logic sel_on;

   assign sel_on = !supply_select_a_n || !supply_select_b_n;

   always_comb
   begin
      run_d = run_q;
      ack_seen_d = ack_seen_q;
      if (power_switch_n == SW_PRESSED_N)
         run_d = (sw_prev_q == SW_RELEASED_N) ? CNT_W'(1) : run_q + CNT_W'(!(&run_q));
      if (!shutdown_req)
         ack_seen_d = 1'b0;
      else if (shutdown_ack)
         ack_seen_d = 1'b1;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         run_q <= '0;
         sw_prev_q <= SW_RELEASED_N;
         ack_seen_q <= 1'b0;
      end
      else
      begin
         run_q <= run_d;
         sw_prev_q <= power_switch_n;
         ack_seen_q <= ack_seen_d;
      end
   end

   // ----------------------------------------
   // properties
   // ----------------------------------------

   sequence s_sel_off;
      chip_select && supply_select_a_n && supply_select_b_n;
   endsequence

   sequence s_req_wait;
      shutdown_req && !shutdown_ack;
   endsequence

   a_ready_sel_off: assert property (s_sel_off [*4] |-> !card_ready)
      else $error("ready high with supply off");
   a_ready_needs_sel: assert property ($rose(card_ready) |-> sel_on && $past(sel_on))
      else $error("ready rose without a selection");
   a_pullup_cs_off: assert property (!chip_select |-> !ready_pullup_en && !fault_pullup_en)
      else $error("pull-up on while deselected");
   a_drive_cs_off: assert property (!chip_select |-> !ready_drive_low && !fault_drive_low)
      else $error("low drive while deselected");
   a_req_holds: assert property (s_req_wait |=> shutdown_req)
      else $error("request dropped before acknowledge");
   a_req_debounced: assert property ($rose(shutdown_req) |-> run_q >= CNT_W'(DEBOUNCE_CYCLES))
      else $error("request on a short press");
   a_fall_after_ack: assert property ($fell(shutdown_req) |-> ack_seen_q)
      else $error("request fell without acknowledge");
   a_float_ack_off: assert property ($rose(shutdown_req) && !ack_oe |-> ##[1:40] !shutdown_req)
      else $error("floating acknowledge did not turn off");
endmodule : card_supply_power_control_checker

// *** card_supply_power_control_tb.sv ***
`timescale 1ns/1ns
module card_supply_power_control_tb;
   import card_pwr_pkg::*;
   // short debounce keeps the run brief
   localparam int DEB = 8;
   logic core_clk, rst, toggle_busy, h_ready, fault_seen, shutdown_pending;
   logic user_card_reset, user_card_clock, user_card_mode, user_chip_select;
   logic user_power_toggle, user_ack_drive, user_ack_grant;
   logic card_present, supply_above_level, supply_fault;
   logic card_rst, card_clk, card_sig_en, usb_link_en, analog_en, main_supply_connect;
   vcc_sel_t user_vcc_sel, vcc_sel;
   vcc_sel_t tv[4] = '{VCC_1V8, VCC_5V0, VCC_3V0, VCC_OFF};
   logic [1:0] tp[4] = '{2'h0, 2'h1, 2'h2, 2'h3};
   int mismatches, check_count;

   card_pwr_if hp();
   card_supply_power_control #(.DEBOUNCE_CYCLES(DEB)) card_supply_power_control_inst (.core_clk,
      .rst, .hp, .card_present, .supply_above_level, .supply_fault, .vcc_sel, .card_rst,
      .card_clk, .card_sig_en, .usb_link_en, .analog_en, .main_supply_connect);
   card_pwr_host #(.DEBOUNCE_CYCLES(DEB)) card_pwr_host_inst (.core_clk, .rst, .hp,
      .user_vcc_sel, .user_card_reset, .user_card_clock, .user_card_mode, .user_chip_select,
      .user_power_toggle, .user_ack_drive, .user_ack_grant, .toggle_busy,
      .card_ready(h_ready), .fault_seen, .shutdown_pending);
   card_supply_power_control_checker #(.DEBOUNCE_CYCLES(DEB)) card_supply_power_control_checker_inst (
      .core_clk, .rst, .supply_select_a_n(hp.supply_select_a_n),
      .supply_select_b_n(hp.supply_select_b_n), .chip_select(hp.chip_select),
      .power_switch_n(hp.power_switch_n), .ack_oe(hp.ack_oe), .shutdown_req(hp.shutdown_req),
      .shutdown_ack(hp.shutdown_ack), .ready_drive_low(hp.ready_drive_low),
      .ready_pullup_en(hp.ready_pullup_en), .fault_drive_low(hp.fault_drive_low),
      .fault_pullup_en(hp.fault_pullup_en), .card_ready(hp.card_ready));

   initial core_clk = 1'b0;
   always #50 core_clk = ~core_clk;

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task wrap_up;
      if (mismatches == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up

   task chk(input logic [2:0] got, input logic [2:0] exp, input string msg);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask : chk

   task cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask : cyc

   function automatic logic sig(input int k);
      case (k)
         0: return analog_en;
         1: return toggle_busy;
         2: return shutdown_pending;
         default: return main_supply_connect;
      endcase
   endfunction : sig

   // bounded wait, a run-out ends the test
   task wait_sig(input int k, input logic v, input int lim);
      int i;
      for (i = 0; i < lim && sig(k) !== v; i++)
         cyc(1);
      chk(sig(k), v, "wait ran out");
      if (sig(k) !== v)
         wrap_up();
   endtask : wait_sig

   // a press is one pulse, the host stretches it
   task press;
      user_power_toggle = 1'b1;
      cyc(1);
      user_power_toggle = 1'b0;
   endtask : press

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial
   begin
      rst = 1'b1;
      user_vcc_sel = VCC_OFF;
      {user_card_reset, user_card_clock, user_power_toggle} = 3'h0;
      // host drives the acknowledge until the floating case near the end
      {user_card_mode, user_chip_select, user_ack_drive, user_ack_grant} = 4'hE;
      {card_present, supply_above_level, supply_fault} = 3'h4;
      mismatches = 0;
      check_count = 0;
      cyc(8);
      rst = 1'b0;
      cyc(2);
      press();
      cyc(3);
      chk(analog_en, 1'b0, "on before debounce");
      wait_sig(0, 1'b1, 100);
      chk(main_supply_connect, 1'b1, "supply not connected");
      wait_sig(1, 1'b0, 100);
      foreach (tv[i])
      begin
         user_vcc_sel = tv[i];
         cyc(4);
         chk({hp.supply_select_a_n, hp.supply_select_b_n}, tp[i], "select pins");
         chk(vcc_sel, tv[i], "supply decode");
      end
      user_vcc_sel = VCC_3V0;
      {user_card_reset, user_card_clock} = 2'h3;
      cyc(6);
      chk(h_ready, 1'b0, "ready before supply");
      chk(card_rst, 1'b0, "reset with low supply");
      supply_above_level = 1'b1;
      cyc(6);
      chk(h_ready, 1'b1, "ready missing");
      chk({card_rst, card_clk}, 2'h3, "reset or clock not passed");
      user_card_clock = 1'b0;
      cyc(4);
      chk(card_clk, 1'b0, "clock not following");
      user_card_mode = 1'b0;
      cyc(4);
      chk({usb_link_en, card_sig_en, card_rst}, 3'h4, "usb mode routing");
      user_card_mode = 1'b1;
      user_chip_select = 1'b0;
      user_vcc_sel = VCC_5V0;
      cyc(4);
      chk(vcc_sel, VCC_3V0, "selection not latched");
      chk(hp.ready_pullup_en | hp.fault_pullup_en, 1'b0, "pull-up while deselected");
      user_chip_select = 1'b1;
      cyc(4);
      chk(vcc_sel, VCC_5V0, "latch not released");
      supply_above_level = 1'b0;
      cyc(6);
      chk({fault_seen, h_ready}, 2'h2, "supply drop not flagged");
      chk(card_rst, 1'b0, "reset with low supply");
      user_vcc_sel = VCC_OFF;
      cyc(6);
      chk({fault_seen, h_ready}, 2'h0, "fault or ready left with supply off");
      card_present = 1'b0;
      user_vcc_sel = VCC_5V0;
      cyc(6);
      chk(fault_seen, 1'b1, "presence change not flagged");
      chk(vcc_sel, VCC_OFF, "activation without card");
      card_present = 1'b1;
      user_vcc_sel = VCC_OFF;
      cyc(8);
      user_vcc_sel = VCC_1V8;
      cyc(6);
      chk(vcc_sel, VCC_1V8, "activation with card");
      supply_fault = 1'b1;
      cyc(6);
      chk(fault_seen, 1'b1, "supply fault not flagged");
      supply_fault = 1'b0;
      user_vcc_sel = VCC_OFF;
      cyc(6);
      user_ack_grant = 1'b0;
      press();
      wait_sig(2, 1'b1, 100);
      cyc(10);
      chk(analog_en, 1'b1, "off without acknowledge");
      user_ack_grant = 1'b1;
      wait_sig(3, 1'b0, 100);
      chk(analog_en, 1'b0, "analog still on");
      {user_ack_drive, user_ack_grant} = 2'h0;
      wait_sig(1, 1'b0, 100);
      cyc(4);
      press();
      wait_sig(0, 1'b1, 100);
      wait_sig(1, 1'b0, 100);
      cyc(4);
      press();
      wait_sig(3, 1'b0, 200);
      chk(analog_en, 1'b0, "analog on after floating acknowledge");
      chk(hp.ready_pullup_en | hp.fault_pullup_en, 1'b0, "pull-up while powered down");
      wrap_up();
   end
endmodule : card_supply_power_control_tb
